// *** design/sfw_cmd_if.sv ***
/*
 Interface that carries a decoded SPI command from the shift engine to the bank.
 Assumes both sides run on mclk.
*/
`timescale 1ns/1ps
interface sfw_cmd_if;
    logic done; // One-cycle pulse at frame end.
    logic [6:0] addr; // Addressed register.
    logic clr; // Mode bit: 1 means clear.
    logic [7:0] rdata; // Byte shifted back out in the next frame's data phase.
    logic bad; // Frame length was not 16 bits.
    modport eng (output done, output addr, output clr, output bad, input rdata);
    modport bank (input done, input addr, input clr, input bad, output rdata);
endinterface // sfw_cmd_if

// *** design/sfw_pkg.sv ***
/*
 Package for the fault and wake status bank: register offsets, field positions,
 reset values, frame layout and enumerations shared by the bank and its helpers.
 Assumes a single 100 MHz core clock and an 8-bit register view.
*/
package sfw_pkg;

    // ==========================================================================
    // Register offsets (7-bit SPI addresses).
    localparam logic [6:0] SFW_ADDR_THERM = 7'h42;
    localparam logic [6:0] SFW_ADDR_DEV = 7'h43;
    localparam logic [6:0] SFW_ADDR_BUSF = 7'h45;
    localparam logic [6:0] SFW_ADDR_WAKE = 7'h46;

    // ==========================================================================
    // Reset values.
    localparam logic [7:0] SFW_RST_VAL = 8'h00;

    // ==========================================================================
    // Field positions.
    localparam int SFW_BIT_SEVERE = 2;
    localparam int SFW_BIT_FIRST = 1;
    localparam int SFW_BIT_PREWARN = 0;
    localparam int SFW_BIT_HIST_LO = 6;
    localparam int SFW_BIT_MISS_LO = 2;
    localparam int SFW_BIT_SPI_BAD = 1;
    localparam int SFW_BIT_FAILURE = 0;
    localparam int SFW_BIT_BUS_LO = 1;
    localparam int SFW_BIT_SUPPLY = 0;
    localparam int SFW_BIT_WK_BUS = 5;
    localparam int SFW_BIT_WK_TMR = 4;

    // ==========================================================================
    // Frame layout: 16 bits, MSB first; bit 7 is the clear mode bit.
    localparam int SFW_FRAME_BITS = 16;
    localparam int SFW_BIT_MODE = 7;
    localparam logic [4:0] SFW_CNT_RST = 5'h00;

    // Pre-restart state codes.
    typedef enum logic [1:0] {
        SFW_HIST_CLEAR = 2'b00,
        SFW_HIST_FAIL = 2'b01,
        SFW_HIST_SLEEP = 2'b10
    } sfw_hist_t;

    // Bus fault codes.
    localparam logic [1:0] SFW_BUS_NONE = 2'b00;
    localparam logic [1:0] SFW_BUS_TSD = 2'b01;
    localparam logic [1:0] SFW_BUS_TXD = 2'b10;
    localparam logic [1:0] SFW_BUS_DOM = 2'b11;

    // Miss counter codes.
    localparam logic [1:0] SFW_MISS_ONE = 2'b01;
    localparam logic [1:0] SFW_MISS_TWO = 2'b10;

endpackage

// *** design/sfw_spi_eng.sv ***
/*
 SPI slave shift engine, mode 0, MSB first. Samples the link pins with mclk
 through two-flop synchronisers and finds the clock edges. Assumes the link
 clock is much slower than mclk.
*/
`timescale 1ns/1ps
module sfw_spi_eng
    import sfw_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Link pins.
    input wire logic sclk,
    input wire logic csn,
    input wire logic sdi,
    output logic sdo,
    // Command carrier.
    sfw_cmd_if.eng cmd
);
    // ==========================================================================
    // Synchronisers; stage one is read only by stage two.
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic sclk_prev_q;
    logic [4:0] cnt_q;
    logic [15:0] sh_q;
    logic [7:0] out_q;
    logic csn_prev_q;

    wire sclk_s = s2_q[2];
    wire csn_s = s2_q[1];
    wire sdi_s = s2_q[0];
    wire rise = sclk_s & ~sclk_prev_q;
    wire fall = ~sclk_s & sclk_prev_q;
    wire frame_end = csn_s & ~csn_prev_q;

    // Two-flop capture of the pins.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 3'h3;
            s2_q <= 3'h3;
        end else begin
            s1_q <= {sclk, csn, sdi};
            s2_q <= s1_q;
        end
    end

    // Shift in on rising edges; shift the read byte out on falling edges.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sclk_prev_q <= 1'b0;
            csn_prev_q <= 1'b1;
            cnt_q <= SFW_CNT_RST;
            sh_q <= 16'h0000;
            out_q <= 8'h00;
            sdo <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            csn_prev_q <= csn_s;
            if (csn_s) begin
                cnt_q <= SFW_CNT_RST;
                out_q <= cmd.rdata;
                sdo <= 1'b0;
            end else if (rise) begin
                sh_q <= {sh_q[14:0], sdi_s};
                cnt_q <= cnt_q + 5'h01;
            end else if (fall && cnt_q >= 5'h08) begin
                // Data phase returns the byte latched between frames.
                sdo <= out_q[7];
                out_q <= {out_q[6:0], 1'b0};
            end
        end
    end

    // Command handed over on the chip-select release.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmd.done <= 1'b0;
            cmd.addr <= 7'h00;
            cmd.clr <= 1'b0;
            cmd.bad <= 1'b0;
        end else begin
            cmd.done <= frame_end;
            if (frame_end) begin
                cmd.addr <= sh_q[15:9];
                cmd.clr <= sh_q[8];
                cmd.bad <= (cnt_q != 5'(SFW_FRAME_BITS));
            end
        end
    end
endmodule // sfw_spi_eng

// *** design/sfw_status_bank.sv ***
/*
 Fault and wake status bank: thermal, device history, bus fault and wake
 status registers read and cleared byte-wise over the SPI link. Assumes the
 mode controller delivers one-cycle event pulses on mclk.
*/
`timescale 1ns/1ps
module sfw_status_bank
    import sfw_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // SPI link.
    input wire logic sclk,
    input wire logic csn,
    input wire logic sdi,
    output logic sdo,
    // Thermal events.
    input wire logic severe_ot_evt,
    input wire logic first_ot_evt,
    input wire logic prewarn_evt,
    // Mode controller events.
    input wire logic restart_fail_evt,
    input wire logic failsafe_wake_evt,
    input wire logic stop_to_sleep_evt,
    input wire logic sleep_no_src_evt,
    input wire logic sleep_flags_evt,
    input wire logic sleep_enter_evt,
    // Watchdog.
    input wire logic wd_miss_evt,
    input wire logic wd_ok_evt,
    input wire logic wd_stop_evt,
    input wire logic wd_stop_by_miss,
    input wire logic [2:0] cfg_sel,
    // Bus transceiver.
    input wire logic [1:0] bus_fault_code,
    input wire logic bus_fault_evt,
    input wire logic supply_low,
    input wire logic xcvr_mode_bit,
    // Wake sources: bus, timer, inputs three to one.
    input wire logic [4:0] wake_evt,
    input wire logic wake_from_failsafe,
    // Results.
    output logic failsafe_req,
    output logic restart_req,
    output logic fault_output_pins,
    output logic tx_disable
);
    import sfw_pkg::*;

    // ==========================================================================
    // Storage and decode.
    sfw_cmd_if cmd_bus(); // Command carrier from the shift engine.
    logic [2:0] therm_q; // Thermal flags.
    logic [1:0] hist_q; // Pre-restart state field.
    logic [1:0] miss_q; // Watchdog miss counter.
    logic spi_bad_q; // Invalid command flag.
    logic failure_q; // Fail output activation flag.
    logic [1:0] bus_code_q; // Bus fault code.
    logic supply_low_q; // Transceiver supply low flag.
    logic [4:0] wake_q; // Wake flags, packed bus/timer/wk3/wk2/wk1.
    logic [7:0] rdata_q; // Byte offered for the next read.
    logic [2:0] d1_q; // Async level synchroniser, stage one.
    logic [2:0] d2_q; // Async level synchroniser, stage two.

    sfw_spi_eng u_eng (
        .mclk(mclk),
        .rstn(rstn),
        .sclk(sclk),
        .csn(csn),
        .sdi(sdi),
        .sdo(sdo),
        .cmd(cmd_bus.eng)
    );

    // A clear carried by a malformed frame is dropped, so a glitch on the
    // link cannot wipe a flag that software has not yet seen.
    // Clear strobes for each register.
    wire clr_cmd = cmd_bus.done & cmd_bus.clr & ~cmd_bus.bad;
    wire clr_therm = clr_cmd && cmd_bus.addr == SFW_ADDR_THERM;
    wire clr_dev = clr_cmd && cmd_bus.addr == SFW_ADDR_DEV;
    wire clr_busf = clr_cmd && cmd_bus.addr == SFW_ADDR_BUSF;
    wire clr_wake = clr_cmd && cmd_bus.addr == SFW_ADDR_WAKE;
    wire known = cmd_bus.addr == SFW_ADDR_THERM || cmd_bus.addr == SFW_ADDR_DEV
        || cmd_bus.addr == SFW_ADDR_BUSF || cmd_bus.addr == SFW_ADDR_WAKE;
    wire bad_cmd = cmd_bus.done & (cmd_bus.bad | ~known);

    // The supply level and mode bit come from analog; synchronised first.
    wire low_s = d2_q[0] & d2_q[1];
    wire cfg_hold = (cfg_sel == 3'h2) || (cfg_sel == 3'h4);
    wire cfg_one_miss = (cfg_sel == 3'h2);
    wire cfg_zero = (cfg_sel == 3'h0);
    // Fail outputs fire at the configured miss count; zero never on first.
    wire [1:0] miss_inc = (miss_q == SFW_MISS_TWO) ? SFW_MISS_TWO : miss_q + 2'h1;
    wire miss_fo = wd_miss_evt && !cfg_zero
        && (cfg_one_miss ? miss_inc == SFW_MISS_ONE : miss_inc == SFW_MISS_TWO);
    wire fo_evt = miss_fo | severe_ot_evt | restart_fail_evt;

    // Sticky set with clear; set wins over a same-cycle clear.
    function automatic logic sticky(input logic q, input logic set, input logic clr);
        sticky = set | (q & ~clr);
    endfunction

    // ==========================================================================
    // Level synchroniser for analog inputs.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            d1_q <= 3'h0;
            d2_q <= 3'h0;
        end else begin
            d1_q <= {1'b0, xcvr_mode_bit, supply_low};
            d2_q <= d1_q;
        end
    end

    // ==========================================================================
    // Thermal flags: only reset or a clear ever lower them.
    // Severe overtemperature also raises the fail-safe request below.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            therm_q <= 3'h0;
        end else begin
            therm_q[SFW_BIT_SEVERE] <= sticky(therm_q[SFW_BIT_SEVERE], severe_ot_evt,
                clr_therm);
            therm_q[SFW_BIT_FIRST] <= sticky(therm_q[SFW_BIT_FIRST], first_ot_evt,
                clr_therm);
            therm_q[SFW_BIT_PREWARN] <= sticky(therm_q[SFW_BIT_PREWARN], prewarn_evt,
                clr_therm);
        end
    end

    // ==========================================================================
    // History field; failure takes priority over the sleep code.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hist_q <= SFW_HIST_CLEAR;
        end else if (restart_fail_evt || failsafe_wake_evt || severe_ot_evt
            || stop_to_sleep_evt || sleep_no_src_evt) begin
            hist_q <= SFW_HIST_FAIL;
        end else if (sleep_flags_evt || sleep_enter_evt) begin
            hist_q <= SFW_HIST_SLEEP;
        end else if (clr_dev) begin
            hist_q <= SFW_HIST_CLEAR;
        end
    end

    // ==========================================================================
    // Watchdog miss counter: the one field that hardware clears itself.
    // The stop qualifier keeps the count visible after a watchdog-caused
    // fail-safe entry, so software can still see why the device restarted.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            miss_q <= 2'h0;
        end else if (wd_miss_evt) begin
            // In hold configurations the count freezes at one after the first miss.
            if (!(cfg_hold && miss_q != 2'h0)) begin
                miss_q <= miss_inc;
            end
        end else if (wd_ok_evt || (wd_stop_evt && !wd_stop_by_miss)) begin
            miss_q <= 2'h0;
        end
    end

    // ==========================================================================
    // Device flags, bus fault and wake flags.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            spi_bad_q <= 1'b0;
            failure_q <= 1'b0;
            bus_code_q <= SFW_BUS_NONE;
            supply_low_q <= 1'b0;
            wake_q <= 5'h00;
        end else begin
            spi_bad_q <= sticky(spi_bad_q, bad_cmd, clr_dev);
            failure_q <= sticky(failure_q, fo_evt, clr_dev);
            if (bus_fault_evt) begin
                bus_code_q <= bus_fault_code;
            end else if (clr_busf) begin
                bus_code_q <= SFW_BUS_NONE;
            end
            supply_low_q <= sticky(supply_low_q, low_s, clr_busf);
            // Fail-safe wakes arrive on the same source lines.
            wake_q <= wake_evt | (wake_q & {5{~clr_wake}});
        end
    end

    // ==========================================================================
    // Outputs, all registered.
    // The fail pins follow the failure flag's set and clear, so the pins and
    // the flag cannot disagree after a clear.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            failsafe_req <= 1'b0;
            restart_req <= 1'b0;
            fault_output_pins <= 1'b0;
            tx_disable <= 1'b0;
        end else begin
            failsafe_req <= severe_ot_evt;
            restart_req <= wd_miss_evt;
            if (fo_evt) begin
                fault_output_pins <= 1'b1;
            end else if (clr_dev) begin
                fault_output_pins <= 1'b0;
            end
            tx_disable <= low_s;
        end
    end

    // ==========================================================================
    // Read mux; reserved positions are constant zero.
    wire [7:0] rd_therm = {5'h00, therm_q};
    wire [7:0] rd_dev = {hist_q, 2'h0, miss_q, spi_bad_q, failure_q};
    wire [7:0] rd_busf = {5'h00, bus_code_q, supply_low_q};
    wire [7:0] rd_wake = {2'h0, wake_q[4:3], 1'b0, wake_q[2:0]};

    // Byte for the next frame follows the address of the last.
    // It is captured as the command lands, so a clear in the same frame
    // still hands the pre-clear value to the controller.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= SFW_RST_VAL;
        end else if (cmd_bus.done) begin
            unique case (cmd_bus.addr)
                SFW_ADDR_THERM: rdata_q <= rd_therm;
                SFW_ADDR_DEV: rdata_q <= rd_dev;
                SFW_ADDR_BUSF: rdata_q <= rd_busf;
                SFW_ADDR_WAKE: rdata_q <= rd_wake;
                default: rdata_q <= SFW_RST_VAL;
            endcase
        end
    end
    assign cmd_bus.rdata = rdata_q;

    // ==========================================================================
    // Checks.
    // Every flag is one register stage behind its event, so most checks look
    // one cycle after the event; the fall checks look back at the clear strobe.
    therm_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
        severe_ot_evt |=> therm_q[SFW_BIT_SEVERE] && failsafe_req)
        else $error("severe flag not set");
    therm_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(therm_q[SFW_BIT_FIRST]) |-> $past(clr_therm))
        else $error("thermal flag fell without clear");
    miss_sat_a: assert property (@(posedge mclk) disable iff (!rstn)
        miss_q != 2'h3)
        else $error("miss counter reached three");
    miss_clr_a: assert property (@(posedge mclk) disable iff (!rstn)
        wd_ok_evt && !wd_miss_evt |=> miss_q == 2'h0)
        else $error("miss counter not cleared");
    spi_bad_a: assert property (@(posedge mclk) disable iff (!rstn)
        bad_cmd |=> spi_bad_q)
        else $error("invalid command not flagged");
    cfg_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        wd_miss_evt && cfg_zero && miss_q == 2'h0 && !severe_ot_evt && !restart_fail_evt
        && !failure_q |=> !failure_q)
        else $error("config zero first miss set failure");
    wake_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
        wake_evt[4] && clr_wake |=> wake_q[4])
        else $error("wake event lost to clear");
    hist_fail_a: assert property (@(posedge mclk) disable iff (!rstn)
        failsafe_wake_evt |=> hist_q == SFW_HIST_FAIL)
        else $error("fail-safe wake not recorded");
    txdis_a: assert property (@(posedge mclk) disable iff (!rstn)
        !d2_q[1] |=> !tx_disable)
        else $error("comparator active while off");
    fo_pins_a: assert property (@(posedge mclk) disable iff (!rstn)
        fo_evt |=> fault_output_pins && failure_q)
        else $error("fail output not flagged");
    busf_load_a: assert property (@(posedge mclk) disable iff (!rstn)
        bus_fault_evt |=> bus_code_q == $past(bus_fault_code))
        else $error("bus fault code not loaded");
    supply_set_a: assert property (@(posedge mclk) disable iff (!rstn)
        low_s |=> supply_low_q && tx_disable)
        else $error("supply low not flagged");
    wake_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(wake_q[0]) |-> $past(clr_wake))
        else $error("wake flag fell without clear");
    hist_sleep_a: assert property (@(posedge mclk) disable iff (!rstn)
        sleep_enter_evt && !restart_fail_evt && !failsafe_wake_evt && !severe_ot_evt
        && !stop_to_sleep_evt && !sleep_no_src_evt |=> hist_q == SFW_HIST_SLEEP)
        else $error("sleep entry not recorded");
endmodule // sfw_status_bank

// *** tb/sfw_mcu_model.sv ***
/*
 Controller model that acts as SPI master on the status bank's link.
 Assumes mode 0 framing, MSB first, and a 100 MHz mclk; sclk runs at 160 ns.
*/
`timescale 1ns/1ps
module sfw_mcu_model (
    // Clock.
    input wire logic mclk,
    // Link pins.
    output logic sclk,
    output logic csn,
    output logic sdi,
    input wire logic sdo
);
    // Link idles with the clock low and the chip deselected.
    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        sdi = 1'b0;
    end

    // ==========================================================================
    // Frame task: nbits sclk pulses; the last 8 sampled bits come back in rd.
    // Half periods are 8 mclk so the bank's synchronisers see every edge.
    task automatic xfer(input logic [6:0] a, input logic c, input int nbits,
                        output logic [7:0] rd);
        logic [15:0] w;
        int i;
        w = {a, c, 8'h00}; // Address first, then the clear mode bit.
        rd = 8'h00;
        @(posedge mclk);
        csn <= 1'b0;
        sdi <= w[15];
        for (i = 0; i < nbits; i++) begin
            repeat (8) @(posedge mclk);
            sclk <= 1'b1;
            rd = {rd[6:0], sdo};
            repeat (8) @(posedge mclk);
            sclk <= 1'b0;
            w = w << 1;
            sdi <= w[15];
        end
        repeat (8) @(posedge mclk);
        csn <= 1'b1;
        // Released data line must not keep its last level.
        sdi <= ~sdi;
        // Gap covers the command latency and the minimum deselect time.
        repeat (8) @(posedge mclk);
    endtask
endmodule // sfw_mcu_model

// *** tb/testbench.sv ***
/*
 Self-checking bench for the fault and wake status bank.
 Assumes the controller model above and the package constants for addresses.
*/
`timescale 1ns/1ps
module testbench;
    import sfw_pkg::*;
    logic mclk, rstn, sclk, csn, sdi, sdo;
    logic [17:0] ev; // Event pulses, one bit per event input.
    logic stop_by_miss, from_fs, supply_low, mode_bit;
    logic [2:0] cfg;
    logic [1:0] code;
    logic fs_req, rs_req, pins, tx_dis;
    logic [1:0] rq;
    logic [7:0] v, d;
    int fail_count, checks, k;

    sfw_mcu_model u_mcu (.mclk(mclk), .sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo));
    sfw_status_bank u_dut (.mclk(mclk), .rstn(rstn), .sclk(sclk), .csn(csn),
        .sdi(sdi), .sdo(sdo), .severe_ot_evt(ev[0]), .first_ot_evt(ev[1]),
        .prewarn_evt(ev[2]), .restart_fail_evt(ev[3]), .failsafe_wake_evt(ev[4]),
        .stop_to_sleep_evt(ev[5]), .sleep_no_src_evt(ev[6]), .sleep_flags_evt(ev[7]),
        .sleep_enter_evt(ev[8]), .wd_miss_evt(ev[9]), .wd_ok_evt(ev[10]),
        .wd_stop_evt(ev[11]), .wd_stop_by_miss(stop_by_miss), .cfg_sel(cfg),
        .bus_fault_code(code), .bus_fault_evt(ev[12]), .supply_low(supply_low),
        .xcvr_mode_bit(mode_bit), .wake_evt(ev[17:13]), .wake_from_failsafe(from_fs),
        .failsafe_req(fs_req), .restart_req(rs_req), .fault_output_pins(pins),
        .tx_disable(tx_dis));

    // ==========================================================================
    // Clock and watchdog.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // The run needs about 30000 cycles; a hang is cut off well beyond that.
    initial begin
        repeat (80000) @(posedge mclk);
        fail_count++;
        finish_test();
    end

    // ==========================================================================
    // Helpers.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pulses events for one cycle and returns the request outputs one cycle later.
    task automatic pulse(input logic [17:0] m, output logic [1:0] r);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= '0;
        #1 r = {fs_req, rs_req};
    endtask

    // A read answer arrives in the following frame, so two frames are sent.
    task automatic rdreg(input logic [6:0] a, output logic [7:0] r);
        u_mcu.xfer(a, 1'b0, 16, d);
        u_mcu.xfer(a, 1'b0, 16, r);
    endtask

    task automatic clr(input logic [6:0] a);
        u_mcu.xfer(a, 1'b1, 16, d);
    endtask

    // Clears a register and lands the event mask in the very cycle the clear acts.
    task automatic clr_race(input logic [6:0] a, input logic [17:0] m);
        fork
            clr(a);
            begin
                // The command strobe is up three edges after the chip-select release.
                @(posedge csn);
                repeat (3) @(posedge mclk);
                ev <= m;
                @(posedge mclk);
                ev <= '0;
            end
        join
    endtask

    // Watchdog step: event, then counter and failure bits plus the fail pins.
    task automatic wstep(input logic [17:0] m, input logic [7:0] e, input logic p);
        pulse(m, rq);
        rdreg(SFW_ADDR_DEV, v);
        chk(v & 8'h3F, e);
        chk({7'h00, pins}, {7'h00, p});
    endtask

    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================================
    // Main sequence.
    initial begin
        rstn = 1'b0; ev = '0; stop_by_miss = 1'b0; from_fs = 1'b0;
        supply_low = 1'b0; mode_bit = 1'b0; cfg = 3'd1; code = 2'b00;
        fail_count = 0; checks = 0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        // Every status register starts cleared.
        rdreg(SFW_ADDR_THERM, v); chk(v, 8'h00);
        rdreg(SFW_ADDR_DEV, v); chk(v, 8'h00);
        rdreg(SFW_ADDR_BUSF, v); chk(v, 8'h00);
        rdreg(SFW_ADDR_WAKE, v); chk(v, 8'h00);
        // Thermal flags, fail-safe request, no self-clearing.
        pulse(18'h00007, rq);
        chk({7'h00, rq[1]}, 8'h01);
        rdreg(SFW_ADDR_THERM, v); chk(v, 8'h07);
        rdreg(SFW_ADDR_THERM, v); chk(v, 8'h07);
        clr(SFW_ADDR_THERM);
        rdreg(SFW_ADDR_THERM, v); chk(v, 8'h00);
        // History codes: four failure causes, then two sleep causes.
        for (k = 0; k < 6; k++) begin
            pulse(18'h1 << (k + 3), rq);
            rdreg(SFW_ADDR_DEV, v);
            // The severe event above left the failure flag up; the restart failure sets it too.
            chk(v, (k == 0) ? 8'h41 : (k < 4) ? 8'h40 : 8'h80);
            clr(SFW_ADDR_DEV);
        end
        rdreg(SFW_ADDR_DEV, v); chk(v, 8'h00);
        // Unknown address, then a short frame.
        u_mcu.xfer(7'h10, 1'b0, 16, d);
        rdreg(SFW_ADDR_DEV, v); chk(v, 8'h02);
        // Cleared first so that the short frame has to raise the flag by itself.
        clr(SFW_ADDR_DEV);
        u_mcu.xfer(SFW_ADDR_DEV, 1'b0, 8, d);
        rdreg(SFW_ADDR_DEV, v); chk(v, 8'h02);
        clr(SFW_ADDR_DEV);
        rdreg(SFW_ADDR_DEV, v); chk(v, 8'h00);
        // Watchdog counter, configuration 1: pins at the second miss.
        pulse(18'h00200, rq);
        chk({7'h00, rq[0]}, 8'h01);
        rdreg(SFW_ADDR_DEV, v); chk(v & 8'h3F, 8'h04);
        wstep(18'h00200, 8'h09, 1'b1);
        wstep(18'h00200, 8'h09, 1'b1);
        wstep(18'h00400, 8'h01, 1'b1);
        clr(SFW_ADDR_DEV);
        // Configuration 2: pins at the first miss, counter frozen.
        cfg <= 3'd2;
        wstep(18'h00200, 8'h05, 1'b1);
        wstep(18'h00200, 8'h05, 1'b1);
        stop_by_miss <= 1'b1;
        wstep(18'h00800, 8'h05, 1'b1);
        stop_by_miss <= 1'b0;
        wstep(18'h00800, 8'h01, 1'b1);
        clr(SFW_ADDR_DEV);
        // Configuration 0: the first miss only requests a restart.
        cfg <= 3'd0;
        pulse(18'h00200, rq);
        chk({7'h00, rq[0]}, 8'h01);
        wstep(18'h00400, 8'h00, 1'b0);
        // Bus fault codes.
        for (k = 1; k < 4; k++) begin
            code <= k[1:0];
            pulse(18'h01000, rq);
            rdreg(SFW_ADDR_BUSF, v); chk(v, {5'h00, k[1:0], 1'b0});
            clr(SFW_ADDR_BUSF);
        end
        // Supply comparator ignored while the mode bit is low.
        supply_low <= 1'b1;
        repeat (10) @(posedge mclk);
        chk({7'h00, tx_dis}, 8'h00);
        rdreg(SFW_ADDR_BUSF, v); chk(v, 8'h00);
        mode_bit <= 1'b1;
        repeat (8) @(posedge mclk);
        chk({7'h00, tx_dis}, 8'h01);
        supply_low <= 1'b0;
        mode_bit <= 1'b0;
        rdreg(SFW_ADDR_BUSF, v); chk(v, 8'h01);
        clr(SFW_ADDR_BUSF);
        rdreg(SFW_ADDR_BUSF, v); chk(v, 8'h00);
        // Wake sources, the last one out of fail-safe.
        for (k = 0; k < 5; k++) begin
            from_fs <= (k == 4);
            pulse(18'h1 << (k + 13), rq);
            rdreg(SFW_ADDR_WAKE, v);
            chk(v, (k < 3) ? (8'h01 << k) : (8'h01 << (k + 1)));
            clr(SFW_ADDR_WAKE);
        end
        // Events that land in the cycle of their register's clear must survive it.
        clr_race(SFW_ADDR_THERM, 18'h00004);
        rdreg(SFW_ADDR_THERM, v); chk(v, 8'h01);
        clr_race(SFW_ADDR_WAKE, 18'h20000);
        rdreg(SFW_ADDR_WAKE, v); chk(v, 8'h20);
        finish_test();
    end
endmodule // testbench
